// ===== rtl/pmc_pkg.sv
package pmc_pkg;

   // Startup times, in ns, as plain defaults
   localparam int REG_UPPER_START_NS = 2000;
   localparam int REG_LOWER_START_NS = 1000;
   localparam int RC_HF_START_NS     = 800;
   localparam int XO_HF_START_NS     = 60000;
   localparam int CLK_MHZ            = 50;
   localparam int REG_UPPER_CYC = (REG_UPPER_START_NS * CLK_MHZ + 999) / 1000;
   localparam int REG_LOWER_CYC = (REG_LOWER_START_NS * CLK_MHZ + 999) / 1000;
   localparam int RC_HF_CYC     = (RC_HF_START_NS * CLK_MHZ + 999) / 1000;
   localparam int XO_HF_CYC     = (XO_HF_START_NS * CLK_MHZ + 999) / 1000;
   localparam int OFF_ENTRY_CYC = 4;
   localparam int CNT_W         = 13;

   // Register map (byte addresses)
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_RETAIN = 4'h4;
   localparam logic [3:0] ADDR_CLKCFG = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hC;

   // CTRL fields
   localparam int CTRL_OFF_REQ    = 0;
   localparam int CTRL_CONST_LAT  = 1;
   localparam int CTRL_BUCK_EN    = 2;
   localparam int CTRL_RADIO_ACT  = 3;
   // CLKCFG fields
   localparam int CFG_HF_SRC_LSB  = 0;
   localparam int CFG_LF_SRC_LSB  = 2;
   localparam int CFG_HF_FORCE    = 4;
   localparam int CFG_LF_FORCE    = 5;
   localparam int CFG_XTAL32      = 6;

   localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] RETAIN_RST = 32'h0000_000F;
   localparam logic [31:0] CLKCFG_RST = 32'h0000_0000;

   typedef enum logic [1:0] {HF_RC = 2'h0, HF_XTAL = 2'h1, HF_EXT = 2'h2} pmc_hf_src_t;
   typedef enum logic [1:0] {LF_RC = 2'h0, LF_XTAL = 2'h1, LF_EXT = 2'h2, LF_SYNTH = 2'h3} pmc_lf_src_t;

   typedef enum {PS_ON, PS_ENTER_OFF, PS_OFF} pmc_pstate_t;

   typedef struct packed {
      logic upper_reg_en;
      logic lower_reg_en;
      logic buck_en;
      logic buck_suspend;
      logic hf_rc_en;
      logic hf_xtal_run;
      logic hf_xtal_standby;
      logic lf_rc_en;
      logic lf_xtal_en;
      logic lf_synth_en;
   } pmc_pwr_ctl_t;

endpackage

// ===== rtl/pmc_power_mode_mgr.sv
`timescale 1ns/1ps
module pmc_power_mode_mgr
   import pmc_pkg::*;
#(
   parameter int NUM_MOD     = 8,
   parameter int RAM_BLOCKS  = 4,
   parameter int XO_START    = XO_HF_CYC
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic [3:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest,
   input  wire logic                  gpio_detect,
   input  wire logic                  analog_wake_signal,
   input  wire logic                  cpu_sleep,
   input  wire logic                  linear_regulator_mode,
   input  wire logic [NUM_MOD-1:0]    mod_hf_req,
   input  wire logic [NUM_MOD-1:0]    mod_lf_req,
   input  wire logic [NUM_MOD-1:0]    mod_task_trig,
   input  wire logic                  radio_hf_req,
   output logic [NUM_MOD-1:0]         mod_hf_gate,
   output logic [NUM_MOD-1:0]         mod_lf_gate,
   output logic [NUM_MOD-1:0]         mod_run,
   output logic [NUM_MOD-1:0]         mod_task_go,
   output logic                       radio_hf_gate,
   output logic                       radio_src_err,
   output logic                       system_on,
   output logic                       tasks_abort,
   output logic                       pin_wake_armed,
   output logic [RAM_BLOCKS-1:0]      ram_retain,
   output pmc_pwr_ctl_t               pwr_ctl,
   output logic                       hf_crystal_thirtytwo,
   output logic                       hf_div2
);

   logic [31:0]       ctrl_r;
   logic [31:0]       retain_r;
   logic [31:0]       clkcfg_r;
   pmc_pstate_t       pstate_r;
   logic [2:0]        entry_cnt_r;
   logic              wake_pend_r;
   logic [CNT_W-1:0]  up_cnt_r;
   logic [CNT_W-1:0]  lo_cnt_r;
   logic [CNT_W-1:0]  hf_cnt_r;
   logic              hf_sel_r;
   logic              hf_rdy;
   logic              up_rdy;
   logic              lo_rdy;
   logic              on;
   logic              wake_any;
   logic              any_hf;
   logic              any_lf;
   logic              hf_need;
   logic              hf_use_xtal;
   logic              lf_synth;
   logic              const_lat;
   logic              res_rdy;
   pmc_hf_src_t       hf_src;
   pmc_lf_src_t       lf_src;
   logic              bus_ack_r;

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] c, input logic en,
                                                 input int lim);
      if (!en) begin
         return '0;
      end else if (c < CNT_W'(lim)) begin
         return c + CNT_W'(1);
      end
      return c;
   endfunction

   assign hf_src      = pmc_hf_src_t'(clkcfg_r[CFG_HF_SRC_LSB +: 2]);
   assign lf_src      = pmc_lf_src_t'(clkcfg_r[CFG_LF_SRC_LSB +: 2]);
   assign const_lat   = ctrl_r[CTRL_CONST_LAT];
   assign on          = (pstate_r == PS_ON);
   assign wake_any    = gpio_detect | analog_wake_signal;
   assign any_hf      = |mod_hf_req;
   assign any_lf      = |mod_lf_req;
   assign lf_synth    = (lf_src == LF_SYNTH) && (any_lf || clkcfg_r[CFG_LF_FORCE]);
   // Synthesis and radio both pin the high-freq source on
   assign hf_need     = on && (any_hf || radio_hf_req || clkcfg_r[CFG_HF_FORCE] || lf_synth
                        || (const_lat && cpu_sleep) || |mod_task_trig);
   assign hf_use_xtal = (hf_src == HF_XTAL) || radio_hf_req;
   assign hf_rdy      = (hf_use_xtal || hf_src == HF_EXT) ? (hf_cnt_r == CNT_W'(XO_START))
                        : (hf_cnt_r == CNT_W'(RC_HF_CYC));
   assign up_rdy      = (up_cnt_r == CNT_W'(REG_UPPER_CYC));
   assign lo_rdy      = (lo_cnt_r == CNT_W'(REG_LOWER_CYC));
   assign res_rdy     = lo_rdy && hf_rdy;

   // Avalon slave: one wait cycle per access, then ack
   assign avs_waitrequest = (avs_read || avs_write) && !bus_ack_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bus_ack_r <= 1'b0;
      end else begin
         bus_ack_r <= (avs_read || avs_write) && !bus_ack_r;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         avs_readdata <= '0;
      end else if (avs_read && !bus_ack_r) begin
         unique case (avs_address)
            ADDR_CTRL:   avs_readdata <= ctrl_r;
            ADDR_RETAIN: avs_readdata <= retain_r;
            ADDR_CLKCFG: avs_readdata <= clkcfg_r;
            ADDR_STATUS: avs_readdata <= {26'h0, hf_use_xtal, radio_src_err, up_rdy, lo_rdy,
                                          hf_rdy, on};
            default:     avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_r   <= CTRL_RST;
         retain_r <= RETAIN_RST;
         clkcfg_r <= CLKCFG_RST;
      end else begin
         // Writes land on the edge where waitrequest is seen low
         if (avs_write && bus_ack_r) begin
            unique case (avs_address)
               ADDR_CTRL:   ctrl_r   <= be_merge(ctrl_r, avs_writedata, avs_byteenable) & 32'h0000_000F;
               ADDR_RETAIN: retain_r <= be_merge(retain_r, avs_writedata, avs_byteenable)
                                        & 32'(({RAM_BLOCKS{1'b1}}));
               ADDR_CLKCFG: clkcfg_r <= be_merge(clkcfg_r, avs_writedata, avs_byteenable) & 32'h0000_007F;
               default: ;
            endcase
         end
         // The off request self-clears once the device has reached System OFF (PS_OFF), not during PS_ENTER_OFF
         if (pstate_r == PS_OFF) begin
            ctrl_r[CTRL_OFF_REQ] <= 1'b0;
         end
      end
   end

   // Power state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pstate_r    <= PS_ON;
         entry_cnt_r <= '0;
         wake_pend_r <= 1'b0;
      end else begin
         unique case (pstate_r)
            PS_ON: begin
               wake_pend_r <= 1'b0;
               entry_cnt_r <= '0;
               if (ctrl_r[CTRL_OFF_REQ]) begin
                  pstate_r <= PS_ENTER_OFF;
               end
            end
            PS_ENTER_OFF: begin
               wake_pend_r <= wake_pend_r | wake_any;
               entry_cnt_r <= entry_cnt_r + 3'h1;
               if (entry_cnt_r == 3'(OFF_ENTRY_CYC - 1)) begin
                  pstate_r <= PS_OFF;
               end
            end
            PS_OFF: begin
               if (wake_any || wake_pend_r) begin
                  pstate_r    <= PS_ON;
                  wake_pend_r <= 1'b0;
               end
            end
         endcase
      end
   end

   // Resource start-up timers; a counter at its limit means ready, except HF on HF_EXT (limit RC_HF_CYC, ready at XO_START)
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         up_cnt_r <= '0;
         lo_cnt_r <= '0;
         hf_cnt_r <= '0;
         hf_sel_r <= 1'b0;
      end else begin
         hf_sel_r <= hf_use_xtal;
         // Low power lets the upper regulator drop while the CPU sleeps
         up_cnt_r <= count_up(up_cnt_r, on && (!cpu_sleep || const_lat), REG_UPPER_CYC);
         lo_cnt_r <= count_up(lo_cnt_r, on && (hf_need || !cpu_sleep || const_lat), REG_LOWER_CYC);
         // A switch to or from the crystal restarts the timer, so a running RC never passes for a started crystal
         hf_cnt_r <= count_up(hf_cnt_r, hf_need && (hf_use_xtal == hf_sel_r),
                              hf_use_xtal ? XO_START : RC_HF_CYC);
      end
   end

   // Clock and task gating
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mod_hf_gate   <= '0;
         mod_lf_gate   <= '0;
         mod_run       <= '0;
         mod_task_go   <= '0;
         radio_hf_gate <= 1'b0;
         radio_src_err <= 1'b0;
      end else begin
         mod_hf_gate   <= on && hf_rdy ? mod_hf_req : '0;
         mod_lf_gate   <= on && (lf_src != LF_SYNTH || hf_rdy) ? mod_lf_req : '0;
         mod_run       <= on ? (mod_hf_req | mod_lf_req | mod_task_trig) : '0;
         // Tasks are held until the lower regulator and clock are up
         mod_task_go   <= on && (const_lat || res_rdy) && res_rdy ? mod_task_trig : '0;
         radio_hf_gate <= on && radio_hf_req && hf_rdy && hf_use_xtal;
         radio_src_err <= radio_hf_req && (hf_src != HF_XTAL);
      end
   end

   // Regulator and oscillator controls
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pwr_ctl              <= '0;
         system_on            <= 1'b1;
         tasks_abort          <= 1'b0;
         pin_wake_armed       <= 1'b0;
         ram_retain           <= '1;
         hf_crystal_thirtytwo <= 1'b0;
         hf_div2              <= 1'b0;
      end else begin
         system_on      <= on;
         tasks_abort    <= !on;
         pin_wake_armed <= (pstate_r == PS_OFF);
         ram_retain     <= on ? {RAM_BLOCKS{1'b1}} : retain_r[RAM_BLOCKS-1:0];
         pwr_ctl.upper_reg_en    <= on && (!cpu_sleep || const_lat);
         pwr_ctl.lower_reg_en    <= on && (hf_need || !cpu_sleep || const_lat);
         pwr_ctl.buck_en         <= on && ctrl_r[CTRL_BUCK_EN] && !linear_regulator_mode;
         pwr_ctl.buck_suspend    <= on && ctrl_r[CTRL_BUCK_EN] && !ctrl_r[CTRL_RADIO_ACT]
                                    && !linear_regulator_mode && cpu_sleep;
         pwr_ctl.hf_rc_en        <= hf_need && !hf_use_xtal && hf_src == HF_RC;
         pwr_ctl.hf_xtal_run     <= hf_need && hf_use_xtal;
         pwr_ctl.hf_xtal_standby <= on && const_lat && cpu_sleep && hf_use_xtal;
         pwr_ctl.lf_rc_en        <= on && (any_lf || clkcfg_r[CFG_LF_FORCE]) && lf_src == LF_RC;
         pwr_ctl.lf_xtal_en      <= on && (any_lf || clkcfg_r[CFG_LF_FORCE]) && lf_src == LF_XTAL;
         pwr_ctl.lf_synth_en     <= on && lf_synth;
         hf_crystal_thirtytwo    <= clkcfg_r[CFG_XTAL32];
         hf_div2                 <= hf_use_xtal && clkcfg_r[CFG_XTAL32];
      end
   end

endmodule

// ===== verification/pmc_chk.sv
`timescale 1ns/1ps
module pmc_chk
   import pmc_pkg::*;
#(
   parameter int NUM_MOD = 8
) (
   input wire logic               clk,
   input wire logic               rst_n,
   input wire logic               gpio_detect,
   input wire logic               analog_wake_signal,
   input wire logic               linear_regulator_mode,
   input wire logic [NUM_MOD-1:0] mod_hf_req,
   input wire logic [NUM_MOD-1:0] mod_hf_gate,
   input wire logic [NUM_MOD-1:0] mod_task_go,
   input wire logic               radio_hf_gate,
   input wire logic               system_on,
   input wire logic               tasks_abort,
   input wire logic               pin_wake_armed,
   input wire pmc_pwr_ctl_t       pwr_ctl,
   input wire logic               hf_crystal_thirtytwo,
   input wire logic               hf_div2
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_wake; !system_on && (gpio_detect || analog_wake_signal); endsequence
   sequence s_ldo; linear_regulator_mode [*2]; endsequence
   property p_off_clk; !system_on |-> mod_hf_gate == '0 && !radio_hf_gate; endproperty
   a_off_clk: assert property (p_off_clk) else $error("clock open while off");
   property p_off_abort; $fell(system_on) |-> tasks_abort && mod_task_go == '0 ##4 pin_wake_armed; endproperty
   a_off_abort: assert property (p_off_abort) else $error("off entry left tasks alive");
   property p_wake; s_wake |-> ##[1:8] system_on; endproperty
   a_wake: assert property (p_wake) else $error("no return to on after wake");
   property p_gate; 1'b1 |-> (mod_hf_gate & ~$past(mod_hf_req)) == '0; endproperty
   a_gate: assert property (p_gate) else $error("clock gated to idle module");
   property p_radio; radio_hf_gate |-> pwr_ctl.hf_xtal_run; endproperty
   a_radio: assert property (p_radio) else $error("radio clock without crystal");
   property p_ldo; s_ldo |-> !pwr_ctl.buck_en; endproperty
   a_ldo: assert property (p_ldo) else $error("buck on in linear mode");
   property p_synth; pwr_ctl.lf_synth_en |-> pwr_ctl.hf_rc_en || pwr_ctl.hf_xtal_run; endproperty
   a_synth: assert property (p_synth) else $error("synth without fast source");
   property p_task; mod_task_go != '0 |-> (pwr_ctl.upper_reg_en || pwr_ctl.lower_reg_en)
      && (pwr_ctl.hf_rc_en || pwr_ctl.hf_xtal_run); endproperty
   a_task: assert property (p_task) else $error("task ran before resources");
   property p_div2; hf_div2 |-> hf_crystal_thirtytwo; endproperty
   a_div2: assert property (p_div2) else $error("halving without fast crystal");
endmodule
bind pmc_power_mode_mgr pmc_chk #(.NUM_MOD(NUM_MOD)) u_chk (
   .clk, .rst_n, .gpio_detect, .analog_wake_signal, .linear_regulator_mode, .mod_hf_req, .mod_hf_gate,
   .mod_task_go, .radio_hf_gate, .system_on, .tasks_abort, .pin_wake_armed, .pwr_ctl, .hf_crystal_thirtytwo,
   .hf_div2
);

// ===== verification/pmc_periph_model.sv
`timescale 1ns/1ps
module pmc_periph_model
   import pmc_pkg::*;
#(
   parameter int NUM_MOD = 4
) (
   input  wire logic [NUM_MOD-1:0] go,
   input  wire logic [NUM_MOD-1:0] hold,
   input  wire logic [NUM_MOD-1:0] mod_hf_gate,
   input  wire logic               clk,
   input  wire logic               rst_n,
   output logic [NUM_MOD-1:0]      mod_hf_req,
   output logic [NUM_MOD-1:0]      mod_lf_req,
   output logic [NUM_MOD-1:0]      mod_task_trig
);
   // A peripheral never drops its request before it has been clocked
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mod_hf_req <= '0;
      end else begin
         mod_hf_req <= go | (mod_hf_req & (hold | ~mod_hf_gate));
      end
   end
   assign mod_lf_req    = mod_hf_req & {NUM_MOD/2{2'b01}};
   assign mod_task_trig = mod_hf_req;
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   import pmc_pkg::*;
   localparam int NM = 4;
   localparam int XO = 8;
   logic              clk, rst_n, avs_read, avs_write, avs_waitrequest;
   logic [3:0]        avs_address, avs_byteenable, ram_retain;
   logic [31:0]       avs_writedata, avs_readdata, q, r;
   logic              gpio_detect, analog_wake_signal, cpu_sleep, linear_regulator_mode, radio_hf_req;
   logic [NM-1:0]     go, hold, mod_hf_req, mod_lf_req, mod_task_trig;
   logic [NM-1:0]     mod_hf_gate, mod_lf_gate, mod_run, mod_task_go;
   logic              radio_hf_gate, radio_src_err, system_on, tasks_abort, pin_wake_armed;
   logic              hf_crystal_thirtytwo, hf_div2;
   pmc_pwr_ctl_t      pwr_ctl;
   int                errors, checks, tmo;

   pmc_power_mode_mgr #(.NUM_MOD(NM), .RAM_BLOCKS(4), .XO_START(XO)) uut (
      .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .gpio_detect, .analog_wake_signal, .cpu_sleep, .linear_regulator_mode, .mod_hf_req,
      .mod_lf_req, .mod_task_trig, .radio_hf_req, .mod_hf_gate, .mod_lf_gate, .mod_run, .mod_task_go,
      .radio_hf_gate, .radio_src_err, .system_on, .tasks_abort, .pin_wake_armed, .ram_retain, .pwr_ctl,
      .hf_crystal_thirtytwo, .hf_div2
   );
   pmc_periph_model #(.NUM_MOD(NM)) u_periph (
      .clk, .rst_n, .go, .hold, .mod_hf_gate, .mod_hf_req, .mod_lf_req, .mod_task_trig
   );

   function automatic logic [31:0] exp_cfg(input logic [31:0] v);
      return v & 32'h0000_007F;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      chk_word(nm, {31'h0, e}, {31'h0, g});
   endtask
   // Request held until the edge where waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      @(negedge clk);
      while (avs_waitrequest !== 1'b0) @(negedge clk);
      @(posedge clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      tmo <= tmo + 1;
      if (tmo == 5000) begin
         errors++;
         test_done();
      end
   end

   initial begin
      {rst_n, avs_read, avs_write, gpio_detect, analog_wake_signal, cpu_sleep} = '0;
      {linear_regulator_mode, radio_hf_req, go, hold, avs_address, avs_writedata, tmo} = '0;
      avs_byteenable = 4'hF;
      void'($urandom(92));
      cyc(5);
      rst_n <= 1'b1;
      bus(0, ADDR_RETAIN, 0); chk_word("retain", RETAIN_RST, q);
      bus(0, ADDR_CLKCFG, 0); chk_word("clkcfg", CLKCFG_RST, q);
      bus(1, 4'h2, $urandom); bus(0, 4'h2, 0); chk_word("unmapped", 32'h0, q);
      repeat (6) begin
         r = $urandom;
         r[1] = 1'b0;
         bus(1, ADDR_CLKCFG, r); bus(0, ADDR_CLKCFG, 0); chk_word("clkcfg", exp_cfg(r), q);
         chk_bit("xtal32", r[6], hf_crystal_thirtytwo);
      end
      bus(1, ADDR_CLKCFG, 32'h0);
      cyc(RC_HF_CYC + 4);
      go <= 4'h5; hold <= 4'h5; cyc(1); go <= '0;
      cyc(RC_HF_CYC + 6); chk_word("hf gate", 32'h5, 32'(mod_hf_gate));
      chk_bit("rc on", 1'b1, pwr_ctl.hf_rc_en);
      hold <= '0; cyc(5); chk_word("hf gate", 32'h0, 32'(mod_hf_gate));
      chk_bit("rc on", 1'b0, pwr_ctl.hf_rc_en);
      bus(1, ADDR_CLKCFG, 32'h10); cyc(RC_HF_CYC + 6); chk_bit("rc on", 1'b1, pwr_ctl.hf_rc_en);
      bus(1, ADDR_CLKCFG, 32'h2C); cyc(RC_HF_CYC + 6); chk_bit("synth", 1'b1, pwr_ctl.lf_synth_en);
      bus(1, ADDR_CLKCFG, 32'h0); radio_hf_req <= 1'b1; cyc(4);
      chk_bit("src err", 1'b1, radio_src_err);
      bus(1, ADDR_CLKCFG, 32'h1); cyc(XO + 6); chk_bit("radio gate", 1'b1, radio_hf_gate);
      chk_bit("src err", 1'b0, radio_src_err);
      bus(1, ADDR_CLKCFG, 32'h41); cyc(4); chk_bit("div2", 1'b1, hf_div2);
      radio_hf_req <= 1'b0;
      bus(1, ADDR_CTRL, 32'h4); linear_regulator_mode <= 1'b1; cyc(4);
      chk_bit("buck", 1'b0, pwr_ctl.buck_en);
      linear_regulator_mode <= 1'b0; cpu_sleep <= 1'b1; cyc(4);
      chk_bit("buck idle", 1'b1, pwr_ctl.buck_suspend);
      bus(1, ADDR_CTRL, 32'hC); cyc(4); chk_bit("buck idle", 1'b0, pwr_ctl.buck_suspend);
      bus(1, ADDR_CLKCFG, 32'h1); bus(1, ADDR_CTRL, 32'h2); cpu_sleep <= 1'b1;
      cyc(REG_UPPER_CYC + XO + 6); chk_bit("upper", 1'b1, pwr_ctl.upper_reg_en);
      chk_bit("lower", 1'b1, pwr_ctl.lower_reg_en);
      chk_bit("xo stby", 1'b1, pwr_ctl.hf_xtal_standby | pwr_ctl.hf_xtal_run);
      bus(1, ADDR_CTRL, 32'h0); cyc(6); chk_bit("upper", 1'b0, pwr_ctl.upper_reg_en);
      go <= 4'h2; hold <= 4'h2; cyc(1); go <= '0;
      cyc(1); chk_word("task", 32'h0, 32'(mod_task_go));
      cyc(REG_UPPER_CYC + XO + 20); chk_word("task", 32'h2, 32'(mod_task_go));
      hold <= '0; cpu_sleep <= 1'b0;
      r = ($urandom & 32'hF) | 32'h1;
      bus(1, ADDR_RETAIN, r); go <= 4'h8; hold <= 4'h8; cyc(1); go <= '0;
      bus(1, ADDR_CTRL, 32'h1); cyc(OFF_ENTRY_CYC + 4); chk_bit("on", 1'b0, system_on);
      chk_word("retain", r, 32'(ram_retain));
      chk_word("hf gate", 32'h0, 32'(mod_hf_gate));
      chk_bit("abort", 1'b1, tasks_abort);
      gpio_detect <= 1'b1; cyc(3); chk_bit("on", 1'b1, system_on);
      gpio_detect <= 1'b0; hold <= '0;
      bus(0, ADDR_CTRL, 0); chk_bit("off req", 1'b0, q[CTRL_OFF_REQ]);
      bus(1, ADDR_CTRL, 32'h1); cyc(1); analog_wake_signal <= 1'b1; cyc(1); analog_wake_signal <= 1'b0;
      cyc(OFF_ENTRY_CYC + 6); chk_bit("on", 1'b1, system_on);
      bus(1, ADDR_CTRL, 32'h1); cyc(OFF_ENTRY_CYC + 4); chk_bit("on", 1'b0, system_on);
      rst_n <= 1'b0; cyc(2); rst_n <= 1'b1; cyc(1); chk_bit("on", 1'b1, system_on);
      test_done();
   end
endmodule
